// ---- bench/smh_assertions.sv ----
// Checker of trigger, cause and select behaviour at the lane block's ports.
// Assumes it is bound into every smh_lanes instance.
`timescale 1ns/1ps
`default_nettype none
module smh_chk (
  input wire logic             clk, rst, enable, execute_in_place_select, xip_req, xip_busy, irq,
  input wire logic             write_queue_port_byte, write_port_ready, transmit_fill_request, receive_drain_request,
  input wire logic [3:0][31:0] dev_region_mask,
  input wire logic [3:0]       halve_address, spi_select_n,
  input wire logic [31:0]      xip_addr,
  input wire logic [5:0]       cause_clear, cause_mask, cause
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Accepted frame that every device region matches
  wire go = enable && execute_in_place_select && xip_req && !xip_busy && dev_region_mask == '0;
  property p_off; !enable || execute_in_place_select |=> !transmit_fill_request && !receive_drain_request; endproperty
  a_off: assert property (p_off) else $error("trigger while off");
  property p_txc; $rose(transmit_fill_request) |-> ##[0:2] cause[0]; endproperty
  a_txc: assert property (p_txc) else $error("tx cause missing");
  property p_rxc; $rose(receive_drain_request) |-> ##[0:2] cause[1]; endproperty
  a_rxc: assert property (p_rxc) else $error("rx cause missing");
  property p_keep; 1 |=> ($past(cause) & ~$past(cause_clear) & ~cause) == 6'h0; endproperty
  a_keep: assert property (p_keep) else $error("cause lost");
  property p_irq; $stable(cause) && $stable(cause_mask) [*2] |-> irq == |(cause & cause_mask); endproperty
  a_irq: assert property (p_irq) else $error("irq wrong");
  property p_ovf; write_queue_port_byte && !write_port_ready && !execute_in_place_select |=> cause[4]; endproperty
  a_ovf: assert property (p_ovf) else $error("no overflow");
  property p_aln; go && (&halve_address) && xip_addr[0] |-> ##[1:3] cause[2]; endproperty
  a_aln: assert property (p_aln) else $error("no align fault");
  property p_sel; go |-> ##[1:3] spi_select_n == 4'h0; endproperty
  a_sel: assert property (p_sel) else $error("select missing");
endmodule : smh_chk
bind smh_lanes smh_chk chk_u (.*);
`default_nettype wire

// ---- bench/smh_mem.sv ----
// Memory model on the far side of the lanes.
// Assumes the host's frame timing; answers byte 5A while selected.
`timescale 1ns/1ps
`default_nettype none
module smh_mem (
  input  wire logic       clk,
  input  wire logic [3:0] spi_select_n,
  output logic      [7:0] spi_data_in = 8'h00
);
  // Selected: bit 7 on lane 7 down to bit 0 on lane 0, lane 1 high; else a toggling pattern
  always @(posedge clk)
  begin
    if (!(&spi_select_n))
      spi_data_in <= 8'h5A;
    else
      spi_data_in <= ~spi_data_in;
  end
endmodule : smh_mem
`default_nettype wire

// ---- bench/test_smh_lanes.sv ----
// Bench: register-mode triggers and causes, one register read, one XIP frame.
// Assumes smh_mem on the lanes and smh_chk bound to the design.
`timescale 1ns/1ps
`default_nettype none
module test_smh_lanes;
  logic clk = 1'b0, rst = 1'b1, enable = 1'b0, execute_in_place_select = 1'b0, xip_req = 1'b0, cmd_write = 1'b0;
  logic write_queue_port_byte = 1'b0, write_queue_port_half = 1'b0, write_queue_port_word = 1'b0;
  logic read_queue_port_byte = 1'b0, read_queue_port_half = 1'b0, read_queue_port_word = 1'b0;
  logic [3:0][31:0] dev_region_base = '0, dev_region_mask = '0;
  logic [3:0][1:0] dev_lane_group = 8'h08;
  logic [3:0] halve_address = 4'hF, tx_trigger_level = 4'h0, rx_trigger_level = 4'h0, spi_select_n;
  logic [1:0] rd_cmd_width = 2'h0, rd_addr_width = 2'h2, rd_addr_bytes_m1 = 2'h2, rd_mode_width = 2'h2;
  logic [1:0] rd_data_width = 2'h3;
  logic [7:0] rd_cmd_code = 8'hEB, rd_mode_code = 8'h00, spi_data_out, spi_data_oe_n, spi_data_in, b, b2;
  logic rd_mode_present = 1'b1, rd_dummy_present = 1'b1, xip_busy, xip_rvalid, write_port_ready, read_valid;
  logic transmit_fill_request, receive_drain_request, irq, spi_clk;
  logic [4:0] rd_dummy_m1 = 5'h3;
  logic [23:0] addr_seen;
  logic [2:0] xip_size = 3'h1;
  logic [31:0] xip_addr = 32'h0000_0003, write_data = 32'h1122_3344, xip_rdata, read_data;
  logic [15:0] cmd_word = 16'h9100;
  logic [5:0] cause_clear = 6'h0, cause_mask = 6'h3F, cause;
  int bad_count = 0, num_checks = 0, cyc = 0;
  smh_lanes dut_u (.*);
  smh_mem mem_u (.clk, .spi_select_n, .spi_data_in);
  // Clock and timeout
  initial forever #2 clk = ~clk;
  always @(posedge clk) if (++cyc == 9000) begin bad_count++; close_out(); end
  task step(input int n); repeat (n) @(posedge clk); #1; endtask : step
  task chk(input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin bad_count++; $display("mismatch %0t: %h not %h", $time, seen, exp); end
  endtask : chk
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : close_out
  // Main sequence
  initial
  begin
    step(3); rst = 0; step(3);
    chk(transmit_fill_request, 0);
    enable = 1; step(3);
    chk({receive_drain_request, transmit_fill_request}, 1);
    chk(cause[0], 1);
    write_queue_port_word = 1; step(1); write_queue_port_word = 0;
    write_queue_port_byte = 1; step(1); write_queue_port_byte = 0; step(6);
    chk({cause[4], irq, transmit_fill_request}, 6);
    tx_trigger_level = 4; step(3); chk(transmit_fill_request, 1);
    cause_clear = 6'h3F; step(1); cause_clear = 0; step(2); chk(cause[4], 0);
    read_queue_port_byte = 1; step(1); read_queue_port_byte = 0; step(3); chk(cause[5], 1);
    cmd_word = 16'h1100; cmd_write = 1; step(1); cmd_write = 0; cmd_word = 16'h9100;
    repeat (8) @(posedge spi_clk) b = {b[6:0], spi_data_out[0]};
    chk(b, 8'h44); step(1);
    cmd_write = 1; step(1); cmd_write = 0;
    while (!receive_drain_request) step(1);
    step(3); chk(cause[1], 1);
    read_queue_port_byte = 1; step(1); read_queue_port_byte = 0;
    while (!read_valid) step(1);
    chk(read_data[7:0], 8'hFF);
    execute_in_place_select = 1; xip_req = 1; step(1); xip_req = 0; step(2);
    chk(transmit_fill_request, 0);
    repeat (8) @(posedge spi_clk) begin b = {b[6:0], spi_data_out[0]}; b2 = {b2[6:0], spi_data_out[4]}; end
    chk(b, smh_pkg::XIP_QUAD_READ_CODE);
    chk(b2, 8'hEB);
    chk(spi_data_oe_n, 8'hEE);
    chk({xip_busy, spi_select_n}, 8'h10);
    repeat (6) @(posedge spi_clk) addr_seen = {addr_seen[19:0], spi_data_out[3:0]};
    chk(addr_seen[7:0], 8'h01);
    chk(addr_seen[23:16] | addr_seen[15:8], 8'h00);
    while (!xip_rvalid) step(1);
    chk(xip_rdata[7:0], 8'h5A);
    chk(cause[2], 1);
    chk({xip_busy, spi_select_n}, 8'h0F);
    close_out();
  end
endmodule : test_smh_lanes
`default_nettype wire

// ---- rtl/smh_lanes.sv ----
// Serial memory host lane engine, request triggers, causes and byte queues.
// Assumes spi_data_in comes from pads; queue ports and settings are on clk.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// Byte queue
// ----------------------------------------------------------------------------
module smh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int CW    = $clog2(DEPTH + 1)
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic      [CW-1:0]    used
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [CW-1:0]               cnt;
  } smh_fifo_s;

  smh_fifo_s q;
  smh_fifo_s d;
  logic      push;
  logic      pop;

  // Flags come from the registered count
  assign in_ready  = (q.cnt != CW'(DEPTH));
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rd];
  assign used      = q.cnt;

  // Pointer and count update
  always_comb
  begin
    d    = q;
    push = in_valid && in_ready;
    pop  = out_valid && out_ready;
    if (push)
    begin
      d.mem[q.wr] = in_data;
      d.wr        = (q.wr == AW'(DEPTH - 1)) ? '0 : AW'(q.wr + 1'b1);
    end
    if (pop)
      d.rd = (q.rd == AW'(DEPTH - 1)) ? '0 : AW'(q.rd + 1'b1);
    if (push && !pop)
      d.cnt = CW'(q.cnt + 1'b1);
    else if (pop && !push)
      d.cnt = CW'(q.cnt - 1'b1);
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
      q <= '0;
    else
      q <= d;
  end
endmodule : smh_fifo

// ----------------------------------------------------------------------------
// Lane engine, triggers and causes
// ----------------------------------------------------------------------------
module smh_lanes #(
  parameter int FIFO_DEPTH = 8,
  parameter int CMD_DEPTH  = 4,
  parameter int CW         = $clog2(FIFO_DEPTH + 1)
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          enable,
  input  wire logic                          execute_in_place_select,
  input  wire logic [3:0][31:0]              dev_region_base,
  input  wire logic [3:0][31:0]              dev_region_mask,
  input  wire logic [3:0][1:0]               dev_lane_group,
  input  wire logic [3:0]                    halve_address,
  input  wire logic [1:0]                    rd_cmd_width,
  input  wire logic [7:0]                    rd_cmd_code,
  input  wire logic [1:0]                    rd_addr_width,
  input  wire logic [1:0]                    rd_addr_bytes_m1,
  input  wire logic                          rd_mode_present,
  input  wire logic [1:0]                    rd_mode_width,
  input  wire logic [7:0]                    rd_mode_code,
  input  wire logic                          rd_dummy_present,
  input  wire logic [4:0]                    rd_dummy_m1,
  input  wire logic [1:0]                    rd_data_width,
  input  wire logic                          xip_req,
  input  wire logic [31:0]                   xip_addr,
  input  wire logic [2:0]                    xip_size,
  output logic                               xip_busy,
  output logic [31:0]                        xip_rdata,
  output logic                               xip_rvalid,
  input  wire logic                          cmd_write,
  input  wire logic [smh_pkg::CMD_BITS-1:0]  cmd_word,
  input  wire logic                          write_queue_port_byte,
  input  wire logic                          write_queue_port_half,
  input  wire logic                          write_queue_port_word,
  input  wire logic [31:0]                   write_data,
  output logic                               write_port_ready,
  input  wire logic                          read_queue_port_byte,
  input  wire logic                          read_queue_port_half,
  input  wire logic                          read_queue_port_word,
  output logic [31:0]                        read_data,
  output logic                               read_valid,
  input  wire logic [CW-1:0]                 tx_trigger_level,
  input  wire logic [CW-1:0]                 rx_trigger_level,
  output logic                               transmit_fill_request,
  output logic                               receive_drain_request,
  input  wire logic [smh_pkg::CAUSE_COUNT-1:0] cause_clear,
  input  wire logic [smh_pkg::CAUSE_COUNT-1:0] cause_mask,
  output logic [smh_pkg::CAUSE_COUNT-1:0]    cause,
  output logic                               irq,
  output logic                               spi_clk,
  output logic [3:0]                         spi_select_n,
  output logic [7:0]                         spi_data_out,
  output logic [7:0]                         spi_data_oe_n,
  input  wire logic [7:0]                    spi_data_in
);
  typedef struct packed {
    smh_pkg::smh_phase_e phase;
    logic [3:0]  sel_n;
    logic        sck;
    logic        half;
    logic        need;
    logic [7:0]  sh;
    logic [2:0]  nib;
    logic [7:0]  bytes_left;
    logic [4:0]  dummy_left;
    logic [1:0]  addr_left;
    logic [31:0] addr_sh;
    logic [1:0]  width;
    logic        dir_rx;
    logic        xip;
    logic        last;
    logic [1:0]  xip_idx;
    logic [7:0]  dout;
    logic [7:0]  doe_n;
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic [15:0] div;
    logic [5:0]  cause;
    logic        irq;
    logic        txreq;
    logic        rxreq;
    logic        busy;
    logic [31:0] xip_data;
    logic        xip_rvalid;
    logic [2:0]  wr_left;
    logic [31:0] wr_sh;
    logic        wr_ready;
    logic [2:0]  rd_left;
    logic [1:0]  rd_idx;
    logic [31:0] rd_acc;
    logic        rd_valid;
  } smh_lanes_s;

  smh_lanes_s q;
  smh_lanes_s d;

  // Queue side signals
  logic                         tx_in_ready;
  logic                         tx_push;
  logic [7:0]                   tx_push_data;
  logic                         tx_out_valid;
  logic                         tx_pop;
  logic [7:0]                   tx_head;
  logic [CW-1:0]                tx_used;
  logic                         rx_in_ready;
  logic                         rx_push;
  logic                         rx_out_valid;
  logic                         rx_pop;
  logic [7:0]                   rx_head;
  logic [CW-1:0]                rx_used;
  logic                         cmd_ready;
  logic                         cmd_valid;
  logic                         cmd_pop;
  logic [smh_pkg::CMD_BITS-1:0] cmd_head;

  // Lanes that carry data for one width
  function automatic logic [7:0] lane_mask(input logic [1:0] w);
    unique case (w)
      smh_pkg::SMH_W_SINGLE: lane_mask = 8'h01;
      smh_pkg::SMH_W_DUAL:   lane_mask = 8'h03;
      smh_pkg::SMH_W_QUAD:   lane_mask = 8'h0F;
      smh_pkg::SMH_W_OCTAL:  lane_mask = 8'hFF;
    endcase
  endfunction : lane_mask

  // Lowest lane of a device's lane group
  function automatic logic [2:0] lane_base(input logic [1:0] grp, input logic [1:0] w);
    lane_base = (w == smh_pkg::SMH_W_OCTAL) ? 3'h0 : {grp, 1'b0};
  endfunction : lane_base

  // Bits moved per serial clock
  function automatic logic [3:0] lane_bits(input logic [1:0] w);
    lane_bits = 4'(4'h1 << w);
  endfunction : lane_bits

  smh_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_tx (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (tx_push),
    .in_ready  (tx_in_ready),
    .in_data   (tx_push_data),
    .out_valid (tx_out_valid),
    .out_ready (tx_pop),
    .out_data  (tx_head),
    .used      (tx_used)
  );

  smh_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (rx_push),
    .in_ready  (rx_in_ready),
    .in_data   (d.sh),
    .out_valid (rx_out_valid),
    .out_ready (rx_pop),
    .out_data  (rx_head),
    .used      (rx_used)
  );

  smh_fifo #(.WIDTH(smh_pkg::CMD_BITS), .DEPTH(CMD_DEPTH)) u_cmd (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (cmd_write && !execute_in_place_select),
    .in_ready  (cmd_ready),
    .in_data   (cmd_word),
    .out_valid (cmd_valid),
    .out_ready (cmd_pop),
    .out_data  (cmd_head),
    .used      ()
  );

  // Next state of the whole block
  always_comb
  begin
    logic [5:0]  set;
    logic [3:0]  act;
    logic [3:0]  match;
    logic [1:0]  lead;
    logic [7:0]  b;
    logic [7:0]  chunk;
    logic [15:0] v;
    logic [15:0] m;
    logic [7:0]  rxc;
    logic [2:0]  wcnt;
    logic [2:0]  rcnt;
    logic [31:0] haddr;
    logic        tick;
    logic        stall;
    set     = '0;
    act     = ~q.sel_n;
    match   = '0;
    lead    = 2'h0;
    b       = q.sh;
    chunk   = 8'h00;
    v       = '0;
    m       = '0;
    rxc     = 8'h00;
    haddr   = xip_addr;
    stall   = 1'b0;
    wcnt    = 3'h0;
    rcnt    = 3'h0;
    d       = q;
    tx_pop  = 1'b0;
    rx_push = 1'b0;
    cmd_pop = 1'b0;
    d.sync1 = spi_data_in;
    d.sync2 = q.sync1;
    d.xip_rvalid = 1'b0;
    d.rd_valid   = 1'b0;
    tick    = (q.div == 16'(smh_pkg::SCK_HALF_CYC - 1));
    d.div   = tick ? 16'h0000 : 16'(q.div + 1'b1);
    for (int i = 3; i >= 0; i--)
      if (act[i])
        lead = 2'(i);
    for (int i = 0; i < 4; i++)
      match[i] = ((xip_addr & dev_region_mask[i]) == (dev_region_base[i] & dev_region_mask[i]));

    // Start a transfer from the idle state
    if (q.phase == smh_pkg::SMH_ST_IDLE)
    begin
      // Park the serial clock low between frames, a full half period after the last rise
      if (tick)
        d.sck = 1'b0;
      if (!enable)
        d.sel_n = smh_pkg::RST_SEL_N;
      else if (execute_in_place_select && xip_req)
      begin
        if (|(match & halve_address))
        begin
          haddr = {1'b0, xip_addr[31:1]};
          if (xip_addr[0] || xip_size[0])
            set[smh_pkg::CAUSE_ALIGN] = 1'b1;
        end
        d.addr_sh    = haddr << {2'(2'h3 - rd_addr_bytes_m1), 3'b000};
        d.addr_left  = rd_addr_bytes_m1;
        d.bytes_left = {5'h00, 3'(xip_size - 3'h1)};
        d.xip        = 1'b1;
        d.xip_idx    = 2'h0;
        d.xip_data   = '0;
        d.dir_rx     = 1'b1;
        d.need       = 1'b1;
        d.half       = 1'b0;
        d.width      = rd_cmd_width;
        if (match == 4'h0)
          d.xip_rvalid = 1'b1;
        else
        begin
          d.sel_n = ~match;
          d.phase = smh_pkg::SMH_ST_CMD;
        end
      end
      else if (!execute_in_place_select && cmd_valid)
      begin
        cmd_pop      = 1'b1;
        d.sel_n      = ~cmd_head[smh_pkg::CMD_SEL_LSB +: 4];
        d.width      = cmd_head[smh_pkg::CMD_W_LSB +: 2];
        d.dir_rx     = cmd_head[smh_pkg::CMD_RX_BIT];
        d.last       = cmd_head[smh_pkg::CMD_LAST_BIT];
        d.bytes_left = cmd_head[smh_pkg::CMD_CNT_LSB +: 8];
        d.xip        = 1'b0;
        d.need       = 1'b1;
        d.half       = 1'b0;
        d.phase      = (cmd_head[smh_pkg::CMD_SEL_LSB +: 4] == 4'h0) ? smh_pkg::SMH_ST_IDLE
                                                                   : smh_pkg::SMH_ST_DATA;
      end
    end
    // Drive edge: serial clock low, next chunk onto the lanes
    else if (tick && !q.half)
    begin
      if (q.phase == smh_pkg::SMH_ST_DATA && q.need && !q.xip)
        stall = q.dir_rx ? !rx_in_ready : !tx_out_valid;
      if (!stall)
      begin
        if (q.need)
        begin
          unique case (q.phase)
            smh_pkg::SMH_ST_CMD:  b = rd_cmd_code;
            smh_pkg::SMH_ST_ADDR: b = q.addr_sh[31:24];
            smh_pkg::SMH_ST_MODE: b = rd_mode_code;
            smh_pkg::SMH_ST_DATA: b = q.dir_rx ? 8'h00 : tx_head;
            default:              b = 8'h00;
          endcase
          tx_pop = (q.phase == smh_pkg::SMH_ST_DATA) && !q.dir_rx && !q.xip;
          d.nib  = 3'(4'h8 >> q.width) - 3'h1;
          d.need = 1'b0;
        end
        d.sh   = b;
        chunk  = b >> (4'h8 - lane_bits(q.width));
        d.dout = 8'h00;
        d.doe_n = smh_pkg::RST_OE_N;
        if (!(q.phase == smh_pkg::SMH_ST_DUMMY || (q.phase == smh_pkg::SMH_ST_DATA && q.dir_rx)))
        begin
          for (int i = 0; i < 4; i++)
            if (act[i])
            begin
              v = {8'h00, chunk & lane_mask(q.width)} << lane_base(dev_lane_group[i], q.width);
              m = {8'h00, lane_mask(q.width)} << lane_base(dev_lane_group[i], q.width);
              d.dout  = d.dout | v[7:0];
              d.doe_n = d.doe_n & ~m[7:0];
            end
        end
        d.sck  = 1'b0;
        d.half = 1'b1;
      end
    end
    // Sample edge: serial clock high, chunk from the lead device
    else if (tick && q.half)
    begin
      d.sck  = 1'b1;
      d.half = 1'b0;
      if (q.width == smh_pkg::SMH_W_SINGLE)
        rxc = {7'h00, q.sync2[3'(lane_base(dev_lane_group[lead], q.width) + 3'h1)]};
      else
        rxc = (q.sync2 >> lane_base(dev_lane_group[lead], q.width)) & lane_mask(q.width);
      d.sh = 8'(q.sh << lane_bits(q.width)) | rxc;
      if (q.phase == smh_pkg::SMH_ST_DUMMY)
      begin
        d.dummy_left = 5'(q.dummy_left - 1'b1);
        if (q.dummy_left == 5'h00)
        begin
          d.phase = smh_pkg::SMH_ST_DATA;
          d.width = rd_data_width;
          d.need  = 1'b1;
        end
      end
      else if (q.nib != 3'h0)
        d.nib = 3'(q.nib - 1'b1);
      else
      begin
        d.need = 1'b1;
        unique case (q.phase)
          smh_pkg::SMH_ST_CMD:
          begin
            d.phase = smh_pkg::SMH_ST_ADDR;
            d.width = rd_addr_width;
          end
          smh_pkg::SMH_ST_ADDR, smh_pkg::SMH_ST_MODE:
          begin
            d.addr_sh   = q.addr_sh << 8;
            d.addr_left = 2'(q.addr_left - 1'b1);
            if (q.phase == smh_pkg::SMH_ST_ADDR && q.addr_left != 2'h0)
              d.phase = smh_pkg::SMH_ST_ADDR;
            else if (q.phase == smh_pkg::SMH_ST_ADDR && rd_mode_present)
            begin
              d.phase = smh_pkg::SMH_ST_MODE;
              d.width = rd_mode_width;
            end
            else if (rd_dummy_present)
            begin
              d.phase      = smh_pkg::SMH_ST_DUMMY;
              d.dummy_left = rd_dummy_m1;
            end
            else
            begin
              d.phase = smh_pkg::SMH_ST_DATA;
              d.width = rd_data_width;
            end
          end
          smh_pkg::SMH_ST_DATA:
          begin
            if (q.xip)
            begin
              d.xip_data[{q.xip_idx, 3'b000} +: 8] = d.sh;
              d.xip_idx = 2'(q.xip_idx + 1'b1);
            end
            else if (q.dir_rx)
              rx_push = 1'b1;
            d.bytes_left = 8'(q.bytes_left - 1'b1);
            if (q.bytes_left == 8'h00)
            begin
              d.phase = smh_pkg::SMH_ST_IDLE;
              d.doe_n = smh_pkg::RST_OE_N;
              d.xip_rvalid = q.xip;
              if (q.xip || q.last)
                d.sel_n = smh_pkg::RST_SEL_N;
            end
          end
          default:
            d.phase = smh_pkg::SMH_ST_IDLE;
        endcase
      end
    end
    d.busy = (d.phase != smh_pkg::SMH_ST_IDLE);

    // Command queue overflow
    if (cmd_write && !execute_in_place_select && !cmd_ready)
      set[smh_pkg::CAUSE_CMD_OVF] = 1'b1;

    // Transmit ports: stage a word, push one byte per cycle
    wcnt = write_queue_port_word ? 3'h4 : write_queue_port_half ? 3'h2 : write_queue_port_byte ? 3'h1 : 3'h0;
    tx_push      = (q.wr_left != 3'h0);
    tx_push_data = q.wr_sh[7:0];
    if (tx_push && tx_in_ready)
    begin
      d.wr_sh   = q.wr_sh >> 8;
      d.wr_left = 3'(q.wr_left - 1'b1);
    end
    if (wcnt != 3'h0 && !execute_in_place_select)
    begin
      if (q.wr_left != 3'h0 || (CW'(FIFO_DEPTH) - tx_used) < CW'(wcnt))
        set[smh_pkg::CAUSE_TX_OVF] = 1'b1;
      else
      begin
        d.wr_sh   = write_data;
        d.wr_left = wcnt;
      end
    end
    d.wr_ready = (d.wr_left == 3'h0);

    // Receive ports: check fill, then pop one byte per cycle
    rcnt   = read_queue_port_word ? 3'h4 : read_queue_port_half ? 3'h2 : read_queue_port_byte ? 3'h1 : 3'h0;
    rx_pop = (q.rd_left != 3'h0);
    if (rx_pop && rx_out_valid)
    begin
      d.rd_acc[{q.rd_idx, 3'b000} +: 8] = rx_head;
      d.rd_idx  = 2'(q.rd_idx + 1'b1);
      d.rd_left = 3'(q.rd_left - 1'b1);
      d.rd_valid = (q.rd_left == 3'h1);
    end
    if (rcnt != 3'h0 && !execute_in_place_select)
    begin
      if (q.rd_left != 3'h0 || rx_used < CW'(rcnt))
        set[smh_pkg::CAUSE_RX_FAULT] = 1'b1;
      else
      begin
        d.rd_left = rcnt;
        d.rd_idx  = 2'h0;
        d.rd_acc  = '0;
      end
    end

    // Level triggers, gated by enable and register mode
    d.txreq = enable && !execute_in_place_select && (tx_used <= tx_trigger_level);
    d.rxreq = enable && !execute_in_place_select && (rx_used > rx_trigger_level);
    set[smh_pkg::CAUSE_TX_REQ] = d.txreq && !q.txreq;
    set[smh_pkg::CAUSE_RX_REQ] = d.rxreq && !q.rxreq;

    // Sticky causes: a set in the clearing cycle wins
    d.cause = (q.cause & ~cause_clear) | set;
    d.irq   = |(d.cause & cause_mask);
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      q       <= '0;
      q.sel_n <= smh_pkg::RST_SEL_N;
      q.doe_n <= smh_pkg::RST_OE_N;
      q.wr_ready <= 1'b1;
    end
    else
      q <= d;
  end

  // Outputs straight from the state register
  assign xip_busy              = q.busy;
  assign xip_rdata             = q.xip_data;
  assign xip_rvalid            = q.xip_rvalid;
  assign write_port_ready      = q.wr_ready;
  assign read_data             = q.rd_acc;
  assign read_valid            = q.rd_valid;
  assign transmit_fill_request = q.txreq;
  assign receive_drain_request = q.rxreq;
  assign cause                 = q.cause;
  assign irq                   = q.irq;
  assign spi_clk               = q.sck;
  assign spi_select_n          = q.sel_n;
  assign spi_data_out          = q.dout;
  assign spi_data_oe_n         = q.doe_n;
endmodule : smh_lanes

`default_nettype wire

// ---- rtl/smh_pkg.sv ----
// Constants, enumerations and field layouts of the serial memory host lane logic.
// Assumes a single 250 MHz system clock; no bus, all settings arrive as ports.
// What this block does
// - Every byte moves most significant bit first, on every lane width.
// - Single width drives write bits on the lowest lane of the device's lane group, reads on the next, eight clocks.
// - Dual width moves two bits per clock, higher bit on higher lane.
// - Quad width sends upper nibble then lower nibble, highest bit highest lane.
// - Octal width moves a whole byte per clock, bit seven on lane seven.
// - Paired quad command, address and mode phases go out in quad width.
// - Paired quad data moves octal: low nibble lanes 3-0, high nibble 7-4.
// - Each read phase has its own width: single 0, quad 2, octal 3.
// - Dummy count and address bytes are minus one; mode, dummy have present flags.
// - Execute-in-place read with 0xEB single, quad address, mode, 4 dummies.
// - Address halving divides the bus address by two before sending.
// - Request triggers work only when enabled and in register mode.
// - Transmit request is active while transmit used count <= its threshold.
// - Receive request is active while receive used count > its threshold.
// - One interrupt line combines six causes.
// - Request causes set when the matching trigger becomes active.
// - Halved access with odd address or odd size raises an alignment fault.
// - Command queue write without free entry raises command overflow.
// - Transmit port write without room raises transmit overflow.
// - Receive port read with too few bytes raises receive fault.
// - Execute-in-place address matching every region selects every matching device.
// - All selected devices receive identical outgoing data at once.
package smh_pkg;

  typedef enum logic [1:0] {
    SMH_W_SINGLE = 2'h0,
    SMH_W_DUAL   = 2'h1,
    SMH_W_QUAD   = 2'h2,
    SMH_W_OCTAL  = 2'h3
  } smh_width_e;

  typedef enum logic [2:0] {
    SMH_ST_IDLE  = 3'h0,
    SMH_ST_CMD   = 3'h1,
    SMH_ST_ADDR  = 3'h2,
    SMH_ST_MODE  = 3'h3,
    SMH_ST_DUMMY = 3'h4,
    SMH_ST_DATA  = 3'h5
  } smh_phase_e;

  // Interrupt cause bit positions
  localparam int CAUSE_TX_REQ   = 0;
  localparam int CAUSE_RX_REQ   = 1;
  localparam int CAUSE_ALIGN    = 2;
  localparam int CAUSE_CMD_OVF  = 3;
  localparam int CAUSE_TX_OVF   = 4;
  localparam int CAUSE_RX_FAULT = 5;
  localparam int CAUSE_COUNT    = 6;

  // Command queue word layout
  localparam int CMD_RX_BIT   = 15;
  localparam int CMD_W_LSB    = 13;
  localparam int CMD_LAST_BIT = 12;
  localparam int CMD_SEL_LSB  = 8;
  localparam int CMD_CNT_LSB  = 0;
  localparam int CMD_BITS     = 16;

  // Serial clock timing
  localparam int CLK_NS       = 4;
  localparam int SCK_HALF_NS  = 80;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;

  // Values after reset
  localparam logic [3:0] RST_SEL_N = 4'hF;
  localparam logic [7:0] RST_OE_N  = 8'hFF;

  // Documented quad read instruction
  localparam logic [7:0] XIP_QUAD_READ_CODE = 8'hEB;

endpackage : smh_pkg
